// ==== swc_cfg.svh ====
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SWC_OFF_MAIN   8'h3a
`define SWC_OFF_TRGBC  8'h3b
`define SWC_OFF_STATUS 8'h3c
`define SWC_OFF_NLOW   8'h24

// ****************************************************************
// reset values
// ****************************************************************
`define SWC_RST_MAIN   8'h00
`define SWC_RST_TRGBC  8'h00
`define SWC_RST_NLOW   8'h00

// ****************************************************************
// field positions in the main control register
// ****************************************************************
`define SWC_BIT_RUN    0
`define SWC_BIT_CLKSRC 1
`define SWC_BIT_PM     2
`define SWC_TRGA_HI    7
`define SWC_TRGA_LO    4

// ****************************************************************
// field positions in the trigger b/c register
// ****************************************************************
`define SWC_TRGB_HI    3
`define SWC_TRGB_LO    0
`define SWC_TRGC_HI    7
`define SWC_TRGC_LO    4

// ****************************************************************
// fixed fractional denominator, two to the 24th
// ****************************************************************
`define SWC_DEN_FIXED  25'h1000000

`endif

// ==== swc_pkg.sv ====
package swc_pkg;

   // sweep sequencing states, gray coded along idle, armed, running
   typedef enum logic [1:0] {
      SWC_IDLE  = 2'h0,
      SWC_ARMED = 2'h1,
      SWC_RUN   = 2'h3
   } swc_state_t;

   // trigger source selector codes
   typedef enum logic [3:0] {
      SWC_TRG_NEVER   = 4'h0,
      SWC_TRG_P1_RISE = 4'h1,
      SWC_TRG_P2_RISE = 4'h2,
      SWC_TRG_MD_RISE = 4'h3,
      SWC_TRG_LK_RISE = 4'h4,
      SWC_TRG_CMP_LVL = 4'h5,
      SWC_TRG_PG_RISE = 4'h6,
      SWC_TRG_F0_RISE = 4'h7,
      SWC_TRG_ALWAYS  = 4'h8,
      SWC_TRG_P1_FALL = 4'h9,
      SWC_TRG_P2_FALL = 4'ha,
      SWC_TRG_MD_FALL = 4'hb,
      SWC_TRG_LK_FALL = 4'hc
   } swc_trig_code_t;

endpackage

// ==== swc_sync.sv ====
`timescale 1ns/1ns

// ****************************************************************
// two flip-flop synchroniser for asynchronous pins
// ****************************************************************
module swc_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // pins in, clean levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;   // first stage, read only by second stage
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;   // second stage
   logic [WIDTH-1:0] sync_d;

   // next values of both stages
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // register both stages
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

// ==== swc_trigsel.sv ====
`timescale 1ns/1ns

// ****************************************************************
// one trigger source selector: edge and level decode per code
// ****************************************************************
module swc_trigsel
   import swc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // selector code from software
   input  wire logic [3:0] code,
   // candidate sources {flag0, pump gain, lock, modulation pin, pin two, pin one}
   input  wire logic [5:0] src,
   input  wire logic       cmp_level,
   // one-cycle trigger for edges, level for level codes
   output logic            fire
);

   logic [5:0] prev_q;   // last sample of each source
   logic [5:0] prev_d;
   logic [5:0] rise;     // sources that went high this cycle
   logic [5:0] fall;     // sources that went low this cycle

   // compare with last sample, pick the source named by the code
   always_comb begin
      prev_d = src;
      rise   = src & ~prev_q;
      fall   = ~src & prev_q;
      case (swc_trig_code_t'(code))
         SWC_TRG_NEVER:   fire = 1'b0;
         SWC_TRG_P1_RISE: fire = rise[0];
         SWC_TRG_P2_RISE: fire = rise[1];
         SWC_TRG_MD_RISE: fire = rise[2];
         SWC_TRG_LK_RISE: fire = rise[3];
         SWC_TRG_CMP_LVL: fire = cmp_level;
         SWC_TRG_PG_RISE: fire = rise[4];
         SWC_TRG_F0_RISE: fire = rise[5];
         SWC_TRG_ALWAYS:  fire = 1'b1;
         SWC_TRG_P1_FALL: fire = fall[0];
         SWC_TRG_P2_FALL: fire = fall[1];
         SWC_TRG_MD_FALL: fire = fall[2];
         SWC_TRG_LK_FALL: fire = fall[3];
         default:         fire = 1'b0;      // unsupported codes stay quiet
      endcase
   end

   // hold last sample
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= prev_d;
      end
   end

endmodule

// ==== swc_top.sv ====
`timescale 1ns/1ns
`include "swc_cfg.svh"

module swc_top
   import swc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // device pins
   input  wire logic        trigger_pin_one,
   input  wire logic        trigger_pin_two,
   input  wire logic        modulation_pin,
   // internal sources from the synthesizer
   input  wire logic        digital_lock_flag,
   input  wire logic        comparator_zero_hit,
   input  wire logic        segment_pump_gain_flag,
   input  wire logic        segment_flag_zero,
   input  wire logic        pd_tick,
   input  wire logic [23:0] prog_den,
   // sweep engine controls
   output logic             sweep_run,
   output logic             sweep_start,
   output logic             sweep_tick,
   output logic             phase_mod_select,
   output logic [24:0]      frac_den,
   output logic [7:0]       div_n_low,
   output logic             event_a,
   output logic             event_b,
   output logic             event_c
);

   // ****************************************************************
   // registers and state
   // ****************************************************************
   logic [7:0]     main_q;      // run, clock source, modulation, source a
   logic [7:0]     main_d;
   logic [7:0]     trgbc_q;     // sources b and c
   logic [7:0]     trgbc_d;
   logic [7:0]     nlow_q;      // integer divider low byte
   logic [7:0]     nlow_d;
   logic [7:0]     rdata_q;     // read data, valid the cycle after the strobe
   logic [7:0]     rdata_d;
   swc_state_t     state_q;     // sequencing state
   swc_state_t     state_d;
   logic           start_q;     // restart at first segment
   logic           start_d;
   logic           tick_q;      // sweep clock enable
   logic           tick_d;
   logic           pm_q;        // phase modulation selected
   logic           pm_d;
   logic [24:0]    den_q;       // denominator in use
   logic [24:0]    den_d;
   logic [2:0]     evt_q;       // trigger events c, b, a
   logic [2:0]     evt_d;
   logic           modpin_prev_q; // last modulation pin sample for clocking
   logic           modpin_prev_d;

   // ****************************************************************
   // pin synchronisers and trigger selectors
   // ****************************************************************
   logic [2:0]     pins_s;      // {modulation, pin two, pin one} after sync
   logic [5:0]     srcs;        // candidate edge sources
   logic [2:0]     fire;        // raw selector outputs c, b, a
   logic           run;         // run bit
   logic           wr_nlow;     // divider low byte write

   swc_sync #(.WIDTH(3)) u_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({modulation_pin, trigger_pin_two, trigger_pin_one}),
      .sync_out (pins_s)
   );

   assign srcs    = {segment_flag_zero, segment_pump_gain_flag,
                     digital_lock_flag, pins_s};
   assign run     = main_q[`SWC_BIT_RUN];
   assign wr_nlow = reg_wr && (reg_addr == `SWC_OFF_NLOW);

   swc_trigsel u_sel_a (
      .clk     (clk),
      .sys_rst (sys_rst),
      .code    (main_q[`SWC_TRGA_HI:`SWC_TRGA_LO]),
      .src     (srcs),
      .cmp_level(comparator_zero_hit),
      .fire    (fire[0])
   );

   swc_trigsel u_sel_b (
      .clk     (clk),
      .sys_rst (sys_rst),
      .code    (trgbc_q[`SWC_TRGB_HI:`SWC_TRGB_LO]),
      .src     (srcs),
      .cmp_level(comparator_zero_hit),
      .fire    (fire[1])
   );

   swc_trigsel u_sel_c (
      .clk     (clk),
      .sys_rst (sys_rst),
      .code    (trgbc_q[`SWC_TRGC_HI:`SWC_TRGC_LO]),
      .src     (srcs),
      .cmp_level(comparator_zero_hit),
      .fire    (fire[2])
   );

   // ****************************************************************
   // register writes and reads
   // ****************************************************************
   always_comb begin
      main_d  = main_q;
      trgbc_d = trgbc_q;
      nlow_d  = nlow_q;
      rdata_d = 8'h00;
      // writes store whole bytes
      if (reg_wr) begin
         case (reg_addr)
            `SWC_OFF_MAIN:  main_d  = reg_wdata;
            `SWC_OFF_TRGBC: trgbc_d = reg_wdata;
            `SWC_OFF_NLOW:  nlow_d  = reg_wdata;
            default:        ;   // unmapped writes ignored
         endcase
      end
      // reads return one cycle later, unmapped reads zero
      if (reg_rd) begin
         case (reg_addr)
            `SWC_OFF_MAIN:   rdata_d = main_q;
            `SWC_OFF_TRGBC:  rdata_d = trgbc_q;
            `SWC_OFF_NLOW:   rdata_d = nlow_q;
            `SWC_OFF_STATUS: rdata_d = {5'h00, pins_s[2], state_q};
            default:         rdata_d = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // sweep sequencing
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      start_d = 1'b0;
      case (state_q)
         SWC_IDLE: begin
            // a divider write in the first running cycle still restarts
            if (run && wr_nlow) begin
               state_d = SWC_RUN;
               start_d = 1'b1;
            end else if (run) begin
               state_d = SWC_ARMED;
            end
         end
         SWC_ARMED, SWC_RUN: begin
            if (!run) begin
               state_d = SWC_IDLE;
            end else if (wr_nlow) begin
               state_d = SWC_RUN;
               start_d = 1'b1;
            end
         end
         default: state_d = SWC_IDLE;
      endcase
   end

   // ****************************************************************
   // clock source, modulation type, denominator, triggers
   // ****************************************************************
   always_comb begin
      modpin_prev_d = pins_s[2];
      // detector clock or rising edge of the modulation pin
      if (main_q[`SWC_BIT_CLKSRC]) begin
         tick_d = run && pins_s[2] && !modpin_prev_q;
      end else begin
         tick_d = run && pd_tick;
      end
      pm_d  = main_q[`SWC_BIT_PM];
      den_d = run ? `SWC_DEN_FIXED : {1'b0, prog_den};
      evt_d = run ? fire : 3'h0;
   end

   // ****************************************************************
   // register all state
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         main_q     <= `SWC_RST_MAIN;
         trgbc_q    <= `SWC_RST_TRGBC;
         nlow_q     <= `SWC_RST_NLOW;
         rdata_q    <= 8'h00;
         state_q    <= SWC_IDLE;
         start_q    <= 1'b0;
         tick_q     <= 1'b0;
         pm_q       <= 1'b0;
         den_q      <= 25'h0000000;
         evt_q      <= 3'h0;
         modpin_prev_q <= 1'b0;
      end else begin
         main_q     <= main_d;
         trgbc_q    <= trgbc_d;
         nlow_q     <= nlow_d;
         rdata_q    <= rdata_d;
         state_q    <= state_d;
         start_q    <= start_d;
         tick_q     <= tick_d;
         pm_q       <= pm_d;
         den_q      <= den_d;
         evt_q      <= evt_d;
         modpin_prev_q <= modpin_prev_d;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata        = rdata_q;
   assign sweep_run        = run;
   assign sweep_start      = start_q;
   assign sweep_tick       = tick_q;
   assign phase_mod_select = pm_q;
   assign frac_den         = den_q;
   assign div_n_low        = nlow_q;
   assign event_a          = evt_q[0];
   assign event_b          = evt_q[1];
   assign event_c          = evt_q[2];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_pm_write;
      reg_wr && reg_addr == `SWC_OFF_MAIN && reg_wdata[`SWC_BIT_PM];
   endsequence

   sequence s_p1_rise;
      pins_s[0] && !$past(pins_s[0]);
   endsequence

   sequence s_p1_fall;
      !pins_s[0] && $past(pins_s[0]);
   endsequence

   AST_STOPPED_QUIET: assert property (!run |=> evt_q == 3'h0 && !tick_q)
      else $error("event or tick while sweep stopped");
   AST_DEN_FIXED: assert property (run |=> frac_den == 25'h1000000)
      else $error("denominator not forced while running");
   AST_START_ON_N: assert property (wr_nlow && run |=> sweep_start)
      else $error("no start after divider low byte write");
   AST_START_CAUSE: assert property (sweep_start |-> $past(wr_nlow) && $past(run))
      else $error("start without divider write");
   AST_TICK_PD: assert property (run && !main_q[1] && pd_tick |=> tick_q)
      else $error("detector clock not passed");
   AST_PM_SET: assert property (s_pm_write |=> ##1 phase_mod_select)
      else $error("phase modulation not selected");
   AST_CODE_NEVER: assert property (main_q[7:4] == 4'h0 |=> !event_a)
      else $error("code zero fired");
   AST_CODE_ALWAYS: assert property (run && trgbc_q[3:0] == 4'h8 |=> event_b)
      else $error("code eight not active");
   AST_P1_RISE: assert property (run && main_q[7:4] == 4'h1 ##0 s_p1_rise |=> event_a)
      else $error("pin one rising edge missed");
   AST_P1_FALL: assert property (run && trgbc_q[7:4] == 4'h9 ##0 s_p1_fall |=> event_c)
      else $error("pin one falling edge missed");
   AST_EDGE_PULSE: assert property (main_q[7:4] == 4'h1 && event_a |=> !event_a)
      else $error("edge trigger longer than one cycle");

   // further steps: main register writes, pin and flag edges, level codes
   sequence s_main_write;
      reg_wr && reg_addr == `SWC_OFF_MAIN;
   endsequence

   sequence s_modpin_rise;
      pins_s[2] && !$past(pins_s[2]);
   endsequence

   sequence s_cmp_sel_a;
      run && main_q[7:4] == 4'h5 && comparator_zero_hit;
   endsequence

   sequence s_lock_rise_b;
      run && trgbc_q[3:0] == 4'h4 && digital_lock_flag && !$past(digital_lock_flag);
   endsequence

   AST_RUN_BIT: assert property (s_main_write |=> sweep_run == $past(reg_wdata[0]))
      else $error("run bit not taken from write");
   AST_DEN_PROG: assert property (!run |=> frac_den == {1'b0, $past(prog_den)})
      else $error("programmed denominator not used while stopped");
   AST_TICK_PIN: assert property (run && main_q[1] ##0 s_modpin_rise |=> sweep_tick)
      else $error("modulation pin edge not passed as clock");
   AST_TICK_NONE: assert property (run && !main_q[1] && !pd_tick |=> !sweep_tick)
      else $error("tick without detector clock");
   AST_PM_CLEAR: assert property (s_main_write ##0 !reg_wdata[2] |=> ##1 !pm_q)
      else $error("frequency modulation not selected");
   AST_CMP_LEVEL: assert property (s_cmp_sel_a |=> event_a)
      else $error("comparator level not passed");
   AST_LOCK_RISE: assert property (s_lock_rise_b |=> event_b)
      else $error("lock rising edge missed");

endmodule

// ==== swc_tb.sv ====
`timescale 1ns/1ns
`include "swc_cfg.svh"

module testbench
   import swc_pkg::*;
;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic        clk;          // 250 mhz clock
   logic        sys_rst;      // synchronous reset
   logic [7:0]  reg_addr;     // register address
   logic [7:0]  reg_wdata;    // register write data
   logic        reg_wr;       // write strobe
   logic        reg_rd;       // read strobe
   logic [7:0]  reg_rdata;    // read data
   logic [7:0]  src_q;        // {tick, flag zero, gain, compare, lock, modulation, pin two, pin one}
   logic [23:0] prog_den;     // programmed denominator
   logic        sweep_run;    // run level
   logic        sweep_start;  // restart pulse
   logic        sweep_tick;   // engine clock enable
   logic        phase_mod_select; // modulation type
   logic [24:0] frac_den;     // denominator in use
   logic [7:0]  div_n_low;    // divider low byte copy
   logic        event_a;      // trigger a
   logic        event_b;      // trigger b
   logic        event_c;      // trigger c
   int          err_total;    // mismatches seen
   int          total_checks; // comparisons made
   int          cyc;          // cycle counter for the hang guard

   // ****************************************************************
   // design under test
   // ****************************************************************
   swc_top dut (
      .clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .trigger_pin_one(src_q[0]), .trigger_pin_two(src_q[1]), .modulation_pin(src_q[2]),
      .digital_lock_flag(src_q[3]), .comparator_zero_hit(src_q[4]),
      .segment_pump_gain_flag(src_q[5]), .segment_flag_zero(src_q[6]),
      .pd_tick(src_q[7]), .prog_den(prog_den),
      .sweep_run(sweep_run), .sweep_start(sweep_start), .sweep_tick(sweep_tick),
      .phase_mod_select(phase_mod_select), .frac_den(frac_den), .div_n_low(div_n_low),
      .event_a(event_a), .event_b(event_b), .event_c(event_c)
   );

   // ****************************************************************
   // clock, inputs at time zero, hang guard
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      src_q     = 8'h00;
      prog_den  = 24'h5a5a5a;
      err_total = 0;
      total_checks = 0;
      cyc       = 0;
   end

   // a run far past the expected length counts as a failure
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total = err_total + 1;
         test_done();
      end
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   // compare one value and count it
   task automatic check(input string name, input logic [24:0] seen, input logic [24:0] expv);
      total_checks = total_checks + 1;
      if (seen !== expv) begin
         err_total = err_total + 1;
         $display("unexpected %s expected %h seen %h", name, expv, seen);
      end
   endtask

   // one-cycle write strobe
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // one-cycle read strobe, data looked at in the following cycle only
   task automatic reg_read(input logic [7:0] a, input logic [7:0] expv);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check("reg_rdata", {17'h00000, reg_rdata}, {17'h00000, expv});
   endtask

   // raise sources in m at cycle 2 (tick for one cycle), lower at 8, count outputs
   task automatic window(input logic [7:0] m, output int ca, output int cb,
                         output int cc, output int ct);
      ca = 0;
      cb = 0;
      cc = 0;
      ct = 0;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (i == 2) src_q <= m;
         if (i == 3) src_q <= {1'b0, m[6:0]};
         if (i == 8) src_q <= 8'h00;
         #1;
         ca = ca + int'(event_a === 1'b1);
         cb = cb + int'(event_b === 1'b1);
         cc = cc + int'(event_c === 1'b1);
         ct = ct + int'(sweep_tick === 1'b1);
      end
   endtask

   // source that a selector code listens to; silent codes get all of them
   function automatic logic [7:0] src_of(input logic [3:0] code);
      case (code)
         4'h1, 4'h9: src_of = 8'h01;
         4'h2, 4'ha: src_of = 8'h02;
         4'h3, 4'hb: src_of = 8'h04;
         4'h4, 4'hc: src_of = 8'h08;
         4'h5:       src_of = 8'h10;
         4'h6:       src_of = 8'h20;
         4'h7:       src_of = 8'h40;
         4'h8:       src_of = 8'h00;
         default:    src_of = 8'h7f;
      endcase
   endfunction

   // event cycles expected in one window for a code
   function automatic int exp_of(input logic [3:0] code);
      case (code)
         4'h0, 4'hd, 4'he, 4'hf: exp_of = 0;
         4'h5:                   exp_of = 6;
         4'h8:                   exp_of = 20;
         default:                exp_of = 1;
      endcase
   endfunction

   // counts and verdict, the single end of the run
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      int ca, cb, cc, ct, e;
      logic [3:0] code;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, unmapped read
      reg_read(`SWC_OFF_MAIN, `SWC_RST_MAIN);
      reg_read(`SWC_OFF_TRGBC, `SWC_RST_TRGBC);
      reg_read(8'h10, 8'h00);
      check("sweep_run", {24'h000000, sweep_run}, 25'h0000000);
      $display("test reset done");
      // stopped: constant trigger stays silent, denominator is programmed one
      reg_write(`SWC_OFF_MAIN, 8'h80);
      reg_write(`SWC_OFF_NLOW, 8'h3c);
      check("sweep_start", {24'h000000, sweep_start}, 25'h0000000);
      window(8'hff, ca, cb, cc, ct);
      check("event_a", 25'(ca), 25'h0000000);
      check("event_bc", 25'(cb + cc), 25'h0000000);
      check("sweep_tick", 25'(ct), 25'h0000000);
      check("frac_den", frac_den, {1'b0, prog_den});
      // running: fixed denominator, start pulse one cycle
      reg_write(`SWC_OFF_MAIN, 8'h01);
      @(posedge clk);
      #1;
      check("frac_den", frac_den, `SWC_DEN_FIXED);
      check("sweep_run", {24'h000000, sweep_run}, 25'h0000001);
      reg_write(`SWC_OFF_NLOW, 8'ha7);
      check("sweep_start", {24'h000000, sweep_start}, 25'h0000001);
      check("div_n_low", {17'h00000, div_n_low}, 25'h00000a7);
      @(posedge clk);
      #1;
      check("sweep_start", {24'h000000, sweep_start}, 25'h0000000);
      reg_read(`SWC_OFF_NLOW, 8'ha7);
      reg_read(`SWC_OFF_STATUS, 8'h03);
      $display("test run and start done");
      // modulation type both ways
      reg_write(`SWC_OFF_MAIN, 8'h05);
      @(posedge clk);
      #1;
      check("phase_mod_select", {24'h000000, phase_mod_select}, 25'h0000001);
      reg_write(`SWC_OFF_MAIN, 8'h01);
      @(posedge clk);
      #1;
      check("phase_mod_select", {24'h000000, phase_mod_select}, 25'h0000000);
      // engine clock source: detector tick or modulation pin edge
      for (int i = 0; i < 4; i++) begin
         reg_write(`SWC_OFF_MAIN, {6'h00, i[1], 1'b1});
         window(i[0] ? 8'h80 : 8'h04, ca, cb, cc, ct);
         e = (i[1] == i[0]) ? 0 : 1;
         check("sweep_tick", 25'(ct), 25'(e));
      end
      $display("test clock source done");
      // every code on every selector
      for (int sel = 0; sel < 3; sel++) begin
         for (int k = 0; k < 16; k++) begin
            code = k[3:0];
            reg_write(`SWC_OFF_MAIN, 8'h00);
            reg_write(`SWC_OFF_TRGBC, {(sel == 2) ? code : 4'h0, (sel == 1) ? code : 4'h0});
            reg_write(`SWC_OFF_MAIN, {(sel == 0) ? code : 4'h0, 4'h1});
            reg_read(`SWC_OFF_MAIN, {(sel == 0) ? code : 4'h0, 4'h1});
            repeat (4) @(posedge clk);
            window(src_of(code), ca, cb, cc, ct);
            check("event_a", 25'(ca), 25'((sel == 0) ? exp_of(code) : 0));
            check("event_b", 25'(cb), 25'((sel == 1) ? exp_of(code) : 0));
            check("event_c", 25'(cc), 25'((sel == 2) ? exp_of(code) : 0));
         end
      end
      $display("test trigger codes done");
      test_done();
   end
endmodule
